// >>> rtl/sbf_top.sv
// apb slave holding the spi buffer status flags and the tx/rx buffers
// Notes on behaviour
// - the tx-empty flag sets when a word moves from tx buffer to shifter.
// - the tx-empty flag clears when the core writes the buffer location, unless a word moves to the shifter in the same cycle.
// - in standard mode the tx-full flag sets on a core buffer write.
// - in standard mode the tx-full flag clears when the shifter takes it.
// - in enhanced mode tx-full is high only when core wptr+1 == shift rptr.
// - in standard mode rx-full sets when the shifter stores a word.
// - in standard mode rx-full clears when the core reads the buffer.
// - in enhanced mode rx-full is high only when shift wptr+1 == core rptr.
// - status bit 2 always reads zero.
`timescale 1ns/1ps
module sbf_top
    import sbf_pkg::*;
(
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // serial data
    input  wire logic        miso_in,
    output logic             busy_q
);
    import sbf_pkg::*;

    // ****************************************
    // bus decode
    // ****************************************
    wire acc      = psel && penable;
    wire hit_stat = (paddr == SBF_STATUS_ADDR);
    wire hit_buf  = (paddr == SBF_BUF_ADDR);
    wire hit_ctrl = (paddr == SBF_CTRL_ADDR);
    wire hit_ptr  = (paddr == SBF_PTR_ADDR);
    wire hit_any  = hit_stat || hit_buf || hit_ctrl || hit_ptr;
    wire buf_wr   = acc && pwrite && hit_buf;
    wire buf_rd   = acc && !pwrite && hit_buf;
    wire ctrl_wr  = acc && pwrite && hit_ctrl;

    logic [31:0] ctrl_q;
    logic        tbe_q;
    logic        tbf_q;
    logic        rbf_q;
    wire         enh = ctrl_q[SBF_ENH_BIT];

    // ****************************************
    // buffers and shifter
    // ****************************************
    logic                  txf_ready;
    logic                  txf_vout;
    logic [SBF_DATA_W-1:0] txf_dout;
    logic [SBF_PTR_W-1:0]  cw_ptr;
    logic [SBF_PTR_W-1:0]  sr_ptr;
    logic                  sh_tx_ready;
    logic                  sh_rx_valid;
    logic [SBF_DATA_W-1:0] sh_rx_data;
    logic                  sh_busy;
    logic                  rxf_ready;
    logic                  rxf_vout;
    logic [SBF_DATA_W-1:0] rxf_dout;
    logic [SBF_PTR_W-1:0]  sw_ptr;
    logic [SBF_PTR_W-1:0]  cr_ptr;

    // standard mode holds one word: only a drained buffer accepts
    wire tx_push   = buf_wr && txf_ready && (enh || !txf_vout);
    wire tx_xfer   = txf_vout && sh_tx_ready;
    wire rx_ok     = enh ? rxf_ready : !rxf_vout;
    wire rx_store  = sh_rx_valid && rx_ok;
    wire rx_pop    = buf_rd && rxf_vout;

    sbf_fifo #(
        .WIDTH (SBF_DATA_W),
        .DEPTH (SBF_FIFO_D),
        .PW    (SBF_PTR_W)
    ) u_tx_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (tx_push),
        .in_ready  (txf_ready),
        .in_data   (pwdata),
        .out_valid (txf_vout),
        .out_ready (sh_tx_ready),
        .out_data  (txf_dout),
        .wr_ptr    (cw_ptr),
        .rd_ptr    (sr_ptr),
        .full      (),
        .empty     ()
    );

    sbf_shifter u_shift (
        .pclk     (pclk),
        .presetn  (presetn),
        .tx_valid (txf_vout),
        .tx_ready (sh_tx_ready),
        .tx_data  (txf_dout),
        .rx_valid (sh_rx_valid),
        .rx_ready (rx_ok),
        .rx_data  (sh_rx_data),
        .loop_en  (ctrl_q[SBF_LOOP_BIT]),
        .miso_in  (miso_in),
        .busy     (sh_busy)
    );

    sbf_fifo #(
        .WIDTH (SBF_DATA_W),
        .DEPTH (SBF_FIFO_D),
        .PW    (SBF_PTR_W)
    ) u_rx_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (rx_store),
        .in_ready  (rxf_ready),
        .in_data   (sh_rx_data),
        .out_valid (rxf_vout),
        .out_ready (rx_pop),
        .out_data  (rxf_dout),
        .wr_ptr    (sw_ptr),
        .rd_ptr    (cr_ptr),
        .full      (),
        .empty     ()
    );

    // ****************************************
    // status flags
    // ****************************************
    wire enh_tbf = ((cw_ptr + SBF_PTR_ONE) == sr_ptr);
    wire enh_rbf = ((sw_ptr + SBF_PTR_ONE) == cr_ptr);

    logic tbe_d;
    logic tbf_d;
    logic rbf_d;
    always_comb begin
        tbe_d = tbe_q;
        if (tx_push) tbe_d = 1'b0;
        if (tx_xfer) tbe_d = 1'b1;
        tbf_d = tbf_q;
        if (tx_xfer) tbf_d = 1'b0;
        if (tx_push) tbf_d = 1'b1;
        rbf_d = rbf_q;
        if (rx_pop)   rbf_d = 1'b0;
        if (rx_store) rbf_d = 1'b1;
        if (enh) begin
            tbf_d = enh_tbf;
            rbf_d = enh_rbf;
        end
    end

    // ****************************************
    // register read mux
    // ****************************************
    wire [31:0] stat_word = {28'h000_0000, tbe_q, 1'b0, tbf_q, rbf_q};
    wire [31:0] ptr_word  = {24'h00_0000, cr_ptr, sw_ptr, sr_ptr, cw_ptr};
    wire [31:0] rd_word   = hit_stat ? stat_word :
                            hit_buf  ? rxf_dout  :
                            hit_ctrl ? ctrl_q    :
                            hit_ptr  ? ptr_word  : SBF_ZERO_WORD;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tbe_q   <= 1'b1;
            tbf_q   <= 1'b0;
            rbf_q   <= 1'b0;
            ctrl_q  <= SBF_CTRL_RST;
            prdata  <= SBF_ZERO_WORD;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            busy_q  <= 1'b0;
        end else begin
            tbe_q   <= tbe_d;
            tbf_q   <= tbf_d;
            rbf_q   <= rbf_d;
            busy_q  <= sh_busy;
            if (ctrl_wr) ctrl_q <= pwdata;
            // ready and data registered from the setup phase, so an access has no wait state
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit_any;
            prdata  <= rd_word;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    // only status reads carry the reserved bit; other words use bit 2
    stat_bit2_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && hit_stat |=> prdata[SBF_UNI_BIT] == 1'b0)
        else $error("status bit 2 not zero");
    stat_read_word_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && hit_stat |=>
            prdata == {28'h000_0000, $past(tbe_q), 1'b0,
                       $past(tbf_q), $past(rbf_q)})
        else $error("status word does not match flags");
    tbe_on_xfer_a: assert property (
        @(posedge pclk) disable iff (!presetn) tx_xfer |=> tbe_q)
        else $error("tx empty not set after transfer");
    tbe_clr_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        tx_push && !tx_xfer |=> !tbe_q)
        else $error("tx empty not cleared by write");
    tbf_std_set_a: assert property (
        @(posedge pclk) disable iff (!presetn) !enh && tx_push |=> tbf_q)
        else $error("tx full not set in standard mode");
    tbf_std_clr_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !enh && tx_xfer && !tx_push |=> !tbf_q)
        else $error("tx full not cleared on transfer");
    tbf_enh_ptr_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        enh |=> tbf_q == $past(enh_tbf))
        else $error("enhanced tx full mismatch");
    rbf_std_set_a: assert property (
        @(posedge pclk) disable iff (!presetn) !enh && rx_store |=> rbf_q)
        else $error("rx full not set on store");
    rbf_std_clr_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !enh && rx_pop && !rx_store |=> !rbf_q)
        else $error("rx full not cleared on read");
    rbf_enh_ptr_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        enh |=> rbf_q == $past(enh_rbf))
        else $error("enhanced rx full mismatch");
    mode_select_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_wr |=> enh == $past(pwdata[SBF_ENH_BIT]))
        else $error("mode bit not taken");
    ctrl_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !ctrl_wr |=> ctrl_q == $past(ctrl_q))
        else $error("control changed without a write");

    // flags move only on their own events
    tbe_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !tx_push && !tx_xfer |=> tbe_q == $past(tbe_q))
        else $error("tx empty moved without an event");
    tbf_std_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !enh && !tx_push && !tx_xfer |=> tbf_q == $past(tbf_q))
        else $error("tx full moved without an event");
    rbf_std_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !enh && !rx_store && !rx_pop |=> rbf_q == $past(rbf_q))
        else $error("rx full moved without an event");
    xfer_starts_shift_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        tx_xfer |=> sh_busy)
        else $error("shifter did not take the word");
    // a word with no room waits in the shifter rather than being lost
    rx_wait_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        sh_rx_valid && !rx_ok |=> sh_busy)
        else $error("shifter dropped a word without room");

    // pointers feed the enhanced flag equations
    push_ptr_step_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        tx_push |=> cw_ptr == $past(cw_ptr) + SBF_PTR_ONE)
        else $error("core write pointer did not advance");
    xfer_ptr_step_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        tx_xfer |=> sr_ptr == $past(sr_ptr) + SBF_PTR_ONE)
        else $error("shifter read pointer did not advance");
    store_ptr_step_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rx_store |=> sw_ptr == $past(sw_ptr) + SBF_PTR_ONE)
        else $error("shifter write pointer did not advance");
    pop_ptr_step_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rx_pop |=> cr_ptr == $past(cr_ptr) + SBF_PTR_ONE)
        else $error("core read pointer did not advance");
    // a refused write must leave no trace in the buffer
    std_refuse_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !enh && buf_wr && txf_vout |=> cw_ptr == $past(cw_ptr))
        else $error("held word overwritten in standard mode");

    // ****************************************
    // bus checks
    // ****************************************
    ready_on_access_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready)
        else $error("no ready in access phase");
    ready_one_cycle_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held beyond one cycle");
    err_unmapped_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && !hit_any |=> pslverr)
        else $error("unmapped access without error");
    err_with_ready_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error answer without ready");
    busy_tracks_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        busy_q == $past(sh_busy))
        else $error("busy output does not follow shifter");
endmodule

// >>> rtl/sbf_pkg.sv
// package: register map, field positions and modes of the spi buffer flags
package sbf_pkg;
    localparam int unsigned SBF_DATA_W = 32;
    localparam int unsigned SBF_FIFO_D = 4;
    localparam int unsigned SBF_PTR_W  = 2;

    // register byte addresses
    localparam logic [11:0] SBF_STATUS_ADDR = 12'h000;
    localparam logic [11:0] SBF_BUF_ADDR    = 12'h004;
    localparam logic [11:0] SBF_CTRL_ADDR   = 12'h008;
    localparam logic [11:0] SBF_PTR_ADDR    = 12'h00C;

    // status field positions
    localparam int unsigned SBF_RBF_BIT = 0;
    localparam int unsigned SBF_TBF_BIT = 1;
    localparam int unsigned SBF_UNI_BIT = 2;
    localparam int unsigned SBF_TBE_BIT = 3;

    // control field positions
    localparam int unsigned SBF_ENH_BIT  = 0;
    localparam int unsigned SBF_LOOP_BIT = 1;

    localparam logic [31:0] SBF_ZERO_WORD = 32'h0000_0000;
    localparam logic [31:0] SBF_CTRL_RST  = 32'h0000_0000;
    localparam logic [3:0]  SBF_SHIFT_CYC = 4'h8;
    localparam logic [3:0]  SBF_SHIFT_ONE = 4'h1;
    localparam logic [1:0]  SBF_PTR_ONE   = 2'h1;

    typedef enum logic [1:0] {
        SBF_SH_IDLE  = 2'b00,
        SBF_SH_SHIFT = 2'b01,
        SBF_SH_STORE = 2'b10
    } sbf_shift_state_type;
endpackage

// >>> rtl/sbf_fifo.sv
// fifo with valid/ready on both sides and exposed pointers
`timescale 1ns/1ps
module sbf_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 4,
    parameter int unsigned PW    = 2
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    // pointers
    output logic [PW-1:0]         wr_ptr,
    output logic [PW-1:0]         rd_ptr,
    output logic                  full,
    output logic                  empty
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW:0]      wp_q;
    logic [PW:0]      rp_q;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign wr_ptr    = wp_q[PW-1:0];
    assign rd_ptr    = rp_q[PW-1:0];
    assign empty     = (wp_q == rp_q);
    assign full      = (wp_q[PW] != rp_q[PW]) && (wr_ptr == rd_ptr);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_q[rd_ptr];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + 1'b1;
            if (pop)  rp_q <= rp_q + 1'b1;
        end
    end

    // storage needs no reset; empty hides stale words
    always_ff @(posedge pclk) begin
        if (push) mem_q[wr_ptr] <= in_data;
    end
endmodule

// >>> rtl/sbf_shifter.sv
// shift engine: takes a word from tx side, returns received word
`timescale 1ns/1ps
module sbf_shifter
    import sbf_pkg::*;
(
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // transmit side
    input  wire logic                  tx_valid,
    output logic                       tx_ready,
    input  wire logic [SBF_DATA_W-1:0] tx_data,
    // receive side
    output logic                       rx_valid,
    input  wire logic                  rx_ready,
    output logic [SBF_DATA_W-1:0]      rx_data,
    // link
    input  wire logic                  loop_en,
    input  wire logic                  miso_in,
    output logic                       busy
);
    sbf_shift_state_type st_q;
    logic [SBF_DATA_W-1:0] sr_q;
    logic [3:0]            cnt_q;
    wire                   in_bit = loop_en ? sr_q[SBF_DATA_W-1] : miso_in;

    assign tx_ready = (st_q == SBF_SH_IDLE);
    assign rx_valid = (st_q == SBF_SH_STORE);
    assign rx_data  = sr_q;
    assign busy     = (st_q != SBF_SH_IDLE);

    // shifting a reduced number of bits keeps the model short
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q  <= SBF_SH_IDLE;
            sr_q  <= '0;
            cnt_q <= '0;
        end else begin
            unique case (st_q)
                SBF_SH_IDLE: if (tx_valid) begin
                    sr_q  <= tx_data;
                    cnt_q <= SBF_SHIFT_CYC;
                    st_q  <= SBF_SH_SHIFT;
                end
                SBF_SH_SHIFT: begin
                    sr_q  <= {sr_q[SBF_DATA_W-2:0], in_bit};
                    cnt_q <= cnt_q - SBF_SHIFT_ONE;
                    if (cnt_q == SBF_SHIFT_ONE) st_q <= SBF_SH_STORE;
                end
                SBF_SH_STORE: if (rx_ready) st_q <= SBF_SH_IDLE;
                default: st_q <= SBF_SH_IDLE;
            endcase
        end
    end
endmodule

// >>> dv/sbf_core_model.sv
// core-side apb master model for the spi buffer flag block
`timescale 1ns/1ps
module sbf_core_model (
    // clock
    input  wire logic        pclk,
    // apb request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    // apb answer
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // one transfer; request held until pready is seen at an edge
    // released lines show the inverse so stale data never looks valid
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // only the bench watchdog ends a wait for pready
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule

// >>> dv/sbf_top_bench.sv
// self-checking bench for the spi buffer status flags
`timescale 1ns/1ps
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin fails++; \
    $display("CHECK FAILED at %0t got %h exp %h", $time, (g), (x)); end end
module sbf_top_bench;
    import sbf_pkg::*;
    typedef struct packed {
        logic        w;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] r;
        logic        e;
    } sbf_row_type;

    localparam logic [31:0] ST_IDLE = 32'h0000_0008;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        miso_in = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, busy_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, p;
    logic        e;
    int          fails = 0;
    int          total_checks = 0;

    // ordinary register accesses: unmapped places answer with an error
    sbf_row_type rows[7] = '{
        '{1'b0, SBF_STATUS_ADDR, 32'h0000_0000, ST_IDLE, 1'b0},
        '{1'b1, SBF_CTRL_ADDR,   32'h0000_0002, 32'h0000_0000, 1'b0},
        '{1'b0, SBF_CTRL_ADDR,   32'h0000_0000, 32'h0000_0002, 1'b0},
        '{1'b0, 12'h010,         32'h0000_0000, 32'h0000_0000, 1'b1},
        '{1'b1, 12'h014,         32'h1234_5678, 32'h0000_0000, 1'b1},
        '{1'b1, SBF_CTRL_ADDR,   32'h0000_0001, 32'h0000_0000, 1'b0},
        '{1'b0, SBF_CTRL_ADDR,   32'h0000_0000, 32'h0000_0001, 1'b0}};

    always #12.5 pclk = ~pclk;
    always @(posedge pclk) miso_in <= ~miso_in;

    sbf_top sbf_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .miso_in(miso_in), .busy_q(busy_q));

    sbf_core_model sbf_core_model_inst (.pclk(pclk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        logic x;
        sbf_core_model_inst.xfer(1'b0, a, SBF_ZERO_WORD, v, x);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] v;
        logic        x;
        sbf_core_model_inst.xfer(1'b1, a, d, v, x);
    endtask

    task automatic do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(SBF_STATUS_ADDR, r);
        `CHK(r, ST_IDLE)
    endtask

    // busy_q rises only two edges after a buffer write lands
    task automatic wait_idle;
        int n;
        n = 0;
        repeat (4) @(posedge pclk);
        while (busy_q !== 1'b0 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (n == 200) fails++;
    endtask

    function automatic logic [31:0] enh_exp(input logic [7:0] q);
        logic [1:0] cw, sr, sw, cr;
        cw = q[1:0];
        sr = q[3:2];
        sw = q[5:4];
        cr = q[7:6];
        return {28'h000_0000, cw == sr, 1'b0,
                cw + SBF_PTR_ONE == sr, sw + SBF_PTR_ONE == cr};
    endfunction

    // pointers read while the shifter is quiet, so they stay stable
    task automatic chk_enh;
        rd(SBF_PTR_ADDR, p);
        rd(SBF_STATUS_ADDR, r);
        `CHK(r, enh_exp(p[7:0]))
    endtask

    initial begin
        do_reset;
        foreach (rows[i]) begin
            sbf_core_model_inst.xfer(rows[i].w, rows[i].a, rows[i].d, r, e);
            `CHK(e, rows[i].e)
            if (!rows[i].w) `CHK(r, rows[i].r)
        end
        // standard mode, loopback, one word
        wr(SBF_CTRL_ADDR, 32'h0000_0002);
        wr(SBF_BUF_ADDR, 32'hA5C3_0F96);
        wait_idle;
        rd(SBF_STATUS_ADDR, r);
        `CHK(r, 32'h0000_0009)
        rd(SBF_BUF_ADDR, r);
        `CHK(r, 32'hC30F_96A5)
        rd(SBF_STATUS_ADDR, r);
        `CHK(r, ST_IDLE)
        // standard mode, serial input, second word waits in tx buffer
        do_reset;
        wr(SBF_CTRL_ADDR, 32'h0000_0000);
        wr(SBF_BUF_ADDR, 32'h0000_00FF);
        wr(SBF_BUF_ADDR, 32'h8000_0001);
        rd(SBF_STATUS_ADDR, r);
        `CHK(r, 32'h0000_0002)
        // second word parks in the shifter until the rx word is read
        repeat (30) @(posedge pclk);
        rd(SBF_STATUS_ADDR, r);
        `CHK(r, 32'h0000_0009)
        `CHK(busy_q, 1'b1)
        rd(SBF_BUF_ADDR, r);
        wait_idle;
        rd(SBF_STATUS_ADDR, r);
        `CHK(r, 32'h0000_0009)
        // enhanced mode: fill rx side unread, then stall the shifter
        do_reset;
        wr(SBF_CTRL_ADDR, 32'h0000_0003);
        for (int i = 0; i < 4; i++) begin
            wr(SBF_BUF_ADDR, 32'h0000_0100 + i);
            wait_idle;
            chk_enh;
        end
        for (int i = 0; i < 4; i++) wr(SBF_BUF_ADDR, 32'h0000_0200 + i);
        repeat (60) @(posedge pclk);
        chk_enh;
        do_reset;
        give_verdict;
    end

    initial begin
        repeat (8000) @(posedge pclk);
        fails++;
        give_verdict;
    end
endmodule
